// ---- design/blank_divider.sv ----
// Reduced-rate square wave used for horizontal clocks during blanking
`timescale 1ns/1ps
`default_nettype none

module blank_divider (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic       blank,
    input  wire logic       pixel_tick,
    input  wire logic [2:0] div,
    output logic            slow_wave
);

    logic [2:0] count_reg;
    logic       last_pix;

    // Half period is div pixels, so full period is twice div pixels
    assign last_pix = (count_reg == (div - 3'h1));

    // ========================================================================
    // Restart phase on each blanking entry so every line looks alike
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= 3'h0;
            slow_wave <= 1'b1;
        end else if (ce) begin
            if (!run || !blank) begin
                count_reg <= 3'h0;
                slow_wave <= 1'b1;
            end else if (pixel_tick) begin
                if (last_pix) begin
                    count_reg <= 3'h0;
                    slow_wave <= ~slow_wave;
                end else begin
                    count_reg <= count_reg + 3'h1;
                end
            end
        end
    end

endmodule : blank_divider
`default_nettype wire

// ---- design/edge_wave.sv ----
// One edge-programmable clock wave inside the pixel period
`timescale 1ns/1ps
`default_nettype none

module edge_wave (
    input  wire logic              sys_clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              run,
    input  wire logic              step_en,
    input  wire logic [5:0]        step,
    input  wire hclk_pkg::edge_cfg_t cfg,
    output logic                   wave
);

    logic hit_rise;
    logic hit_fall;

    // Edge matches against the running step position
    assign hit_rise = step_en && (step == cfg.rise);
    assign hit_fall = step_en && (step == cfg.fall);

    // ========================================================================
    // Rise wins when both sit on one step so a mis-set pair never sticks low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wave <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                wave <= 1'b0;
            end else if (hit_rise) begin
                wave <= 1'b1;
            end else if (hit_fall) begin
                wave <= 1'b0;
            end
        end
    end

endmodule : edge_wave
`default_nettype wire

// ---- design/hclk_pkg.sv ----
// Shared constants, register map and carrier types of the horizontal clock block
package hclk_pkg;

    // ========================================================================
    // Serial frame layout
    localparam int ADDR_BITS  = 8;
    localparam int DATA_BITS  = 24;
    localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;

    // ========================================================================
    // Register offsets
    localparam logic [7:0] ADDR_CORE_RUN  = 8'h15;
    localparam logic [7:0] ADDR_CLK_HALVE = 8'h30;
    localparam logic [7:0] ADDR_PAIR_A    = 8'h31;
    localparam logic [7:0] ADDR_PAIR_B    = 8'h32;
    localparam logic [7:0] ADDR_LAST      = 8'h33;
    localparam logic [7:0] ADDR_RGATE     = 8'h34;
    localparam logic [7:0] ADDR_RETIME    = 8'h35;
    localparam logic [7:0] ADDR_DRIVE     = 8'h36;

    // ========================================================================
    // Field positions
    localparam int POS_W        = 6;
    localparam int RISE_LSB     = 0;
    localparam int FALL_LSB     = 8;
    localparam int POL_BIT      = 16;
    localparam int RETIME_W     = 7;
    localparam int DIV_W        = 3;
    localparam int DRIVE_W      = 24;
    localparam int NUM_CH       = 4;
    localparam int CH_PAIR_A    = 0;
    localparam int CH_PAIR_B    = 1;
    localparam int CH_LAST      = 2;
    localparam int CH_RGATE     = 3;

    // ========================================================================
    // Reset values
    localparam logic [5:0]  RISE_RST      = 6'h00;
    localparam logic [5:0]  FALL_RST_H    = 6'h14;
    localparam logic [5:0]  FALL_RST_RG   = 6'h0A;
    localparam logic        POL_RST       = 1'b1;
    localparam logic        HALVE_RST     = 1'b0;
    localparam logic        CORE_RUN_RST  = 1'b0;
    localparam logic [6:0]  RETIME_RST    = 7'h00;
    localparam logic [23:0] DRIVE_RST     = 24'h111111;

    // ========================================================================
    // Timing counts
    localparam int PIXEL_STEPS = 64;

    // ========================================================================
    // Carrier types
    typedef struct packed {
        logic       pol;
        logic [5:0] fall;
        logic [5:0] rise;
    } edge_cfg_t;

    typedef struct packed {
        logic [2:0] div;
        logic       last_stage_blank_enable;
        logic [2:0] resync;
    } retime_cfg_t;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_SHIFT,
        SER_DONE
    } ser_state_t;

endpackage : hclk_pkg

// ---- design/hclk_timing.sv ----
// Horizontal and reset gate clock generator with serial register port
`timescale 1ns/1ps
`default_nettype none

module hclk_timing #(
    parameter int PIXEL_STEPS = hclk_pkg::PIXEL_STEPS
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        serial_clock,
    input  wire logic        serial_load_n,
    input  wire logic        serial_data,
    input  wire logic        horizontal_blanking,
    output logic             horizontal_clock_one,
    output logic             horizontal_clock_two,
    output logic             horizontal_clock_three,
    output logic             horizontal_clock_four,
    output logic             last_stage_horizontal_clock,
    output logic             reset_gate_clock,
    output logic [23:0]      drive_levels,
    output logic             core_running
);

    // ========================================================================
    // Serial port state
    hclk_pkg::ser_state_t                 ser_state_reg;
    hclk_pkg::ser_state_t                 ser_state_next;
    logic [hclk_pkg::FRAME_BITS-1:0]      shift_reg;
    logic [5:0]                           bit_count_reg;
    logic                                 sck_prev_reg;
    logic                                 sck_rise;
    logic                                 last_bit;
    logic [hclk_pkg::FRAME_BITS-1:0]      frame_word;
    logic [7:0]                           wr_addr;
    logic [23:0]                          wr_data;
    logic                                 wr_strobe;

    // ========================================================================
    // Register file
    logic                                 input_clock_halve_reg;
    logic                                 timing_core_run_n_reg;
    hclk_pkg::edge_cfg_t                  edge_cfg_reg [hclk_pkg::NUM_CH];
    hclk_pkg::retime_cfg_t                retime_reg;
    logic [23:0]                          drive_reg;
    hclk_pkg::edge_cfg_t                  wr_edge_cfg;

    // ========================================================================
    // Pixel timing state
    logic                                 run;
    logic                                 halve_phase_reg;
    logic                                 step_en;
    logic [5:0]                           step_reg;
    logic                                 step_wrap;
    logic                                 pixel_tick;
    logic [hclk_pkg::NUM_CH-1:0]          wave;
    logic [hclk_pkg::NUM_CH-1:0]          blank_rt_reg;
    logic [hclk_pkg::NUM_CH-1:0]          blank_eff;
    logic [hclk_pkg::NUM_CH-1:0]          shaped;
    logic [hclk_pkg::NUM_CH-1:0]          pol_out;
    logic                                 slow_wave;
    logic                                 any_blank;
    logic                                 slow_mode;

    // ========================================================================
    // Serial decode: inputs are synchronous, so edges come from one sample
    assign sck_rise   = serial_clock && !sck_prev_reg;
    assign last_bit   = (bit_count_reg == 6'(hclk_pkg::FRAME_BITS - 1));
    assign frame_word = {serial_data, shift_reg[hclk_pkg::FRAME_BITS-1:1]};
    assign wr_addr    = frame_word[hclk_pkg::ADDR_BITS-1:0];
    assign wr_data    = frame_word[hclk_pkg::FRAME_BITS-1:hclk_pkg::ADDR_BITS];
    assign wr_strobe  = (ser_state_reg == hclk_pkg::SER_SHIFT) && !serial_load_n
                        && sck_rise && last_bit;

    // Field view of the incoming word for the edge registers
    assign wr_edge_cfg.rise = wr_data[hclk_pkg::RISE_LSB +: hclk_pkg::POS_W];
    assign wr_edge_cfg.fall = wr_data[hclk_pkg::FALL_LSB +: hclk_pkg::POS_W];
    assign wr_edge_cfg.pol  = wr_data[hclk_pkg::POL_BIT];

    // ========================================================================
    // Frame sequencer: bits beyond the frame are ignored until load rises
    always_comb begin
        ser_state_next = ser_state_reg;
        unique case (ser_state_reg)
            hclk_pkg::SER_IDLE: begin
                if (!serial_load_n) begin
                    ser_state_next = hclk_pkg::SER_SHIFT;
                end
            end
            hclk_pkg::SER_SHIFT: begin
                if (serial_load_n) begin
                    ser_state_next = hclk_pkg::SER_IDLE;
                end else if (sck_rise && last_bit) begin
                    ser_state_next = hclk_pkg::SER_DONE;
                end
            end
            hclk_pkg::SER_DONE: begin
                if (serial_load_n) begin
                    ser_state_next = hclk_pkg::SER_IDLE;
                end
            end
        endcase
    end

    // Shift in LSB first, address byte before data
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ser_state_reg <= hclk_pkg::SER_IDLE;
            shift_reg     <= '0;
            bit_count_reg <= 6'h00;
            sck_prev_reg  <= 1'b0;
        end else if (ce) begin
            ser_state_reg <= ser_state_next;
            sck_prev_reg  <= serial_clock;
            if (ser_state_reg != hclk_pkg::SER_SHIFT) begin
                bit_count_reg <= 6'h00;
            end else if (sck_rise && !serial_load_n) begin
                shift_reg     <= frame_word;
                bit_count_reg <= bit_count_reg + 6'h01;
            end
        end
    end

    // ========================================================================
    // Register writes land on the completing edge, no frame boundary wait
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            input_clock_halve_reg <= hclk_pkg::HALVE_RST;
            timing_core_run_n_reg <= hclk_pkg::CORE_RUN_RST;
            edge_cfg_reg[hclk_pkg::CH_PAIR_A] <= '{hclk_pkg::POL_RST,
                hclk_pkg::FALL_RST_H, hclk_pkg::RISE_RST};
            edge_cfg_reg[hclk_pkg::CH_PAIR_B] <= '{hclk_pkg::POL_RST,
                hclk_pkg::FALL_RST_H, hclk_pkg::RISE_RST};
            edge_cfg_reg[hclk_pkg::CH_LAST]   <= '{hclk_pkg::POL_RST,
                hclk_pkg::FALL_RST_H, hclk_pkg::RISE_RST};
            edge_cfg_reg[hclk_pkg::CH_RGATE]  <= '{hclk_pkg::POL_RST,
                hclk_pkg::FALL_RST_RG, hclk_pkg::RISE_RST};
            retime_reg            <= hclk_pkg::RETIME_RST;
            drive_reg             <= hclk_pkg::DRIVE_RST;
        end else if (ce && wr_strobe) begin
            unique case (wr_addr)
                hclk_pkg::ADDR_CORE_RUN:  timing_core_run_n_reg <= wr_data[0];
                hclk_pkg::ADDR_CLK_HALVE: input_clock_halve_reg <= wr_data[0];
                hclk_pkg::ADDR_PAIR_A:    edge_cfg_reg[hclk_pkg::CH_PAIR_A] <= wr_edge_cfg;
                hclk_pkg::ADDR_PAIR_B:    edge_cfg_reg[hclk_pkg::CH_PAIR_B] <= wr_edge_cfg;
                hclk_pkg::ADDR_LAST:      edge_cfg_reg[hclk_pkg::CH_LAST]   <= wr_edge_cfg;
                hclk_pkg::ADDR_RGATE:     edge_cfg_reg[hclk_pkg::CH_RGATE]  <= wr_edge_cfg;
                hclk_pkg::ADDR_RETIME:    retime_reg <= wr_data[hclk_pkg::RETIME_W-1:0];
                hclk_pkg::ADDR_DRIVE:     drive_reg  <= wr_data[hclk_pkg::DRIVE_W-1:0];
                default: ; // Other addresses belong to other blocks
            endcase
        end
    end

    // ========================================================================
    // Pixel step counter; halving drops every other master clock cycle
    assign run        = timing_core_run_n_reg;
    assign step_en    = run && (!input_clock_halve_reg || halve_phase_reg);
    assign step_wrap  = (step_reg == 6'(PIXEL_STEPS - 1));
    assign pixel_tick = step_en && step_wrap;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            halve_phase_reg <= 1'b0;
            step_reg        <= 6'h00;
        end else if (ce) begin
            if (!run) begin
                halve_phase_reg <= 1'b0;
                step_reg        <= 6'h00;
            end else begin
                halve_phase_reg <= ~halve_phase_reg;
                if (step_en) begin
                    step_reg <= step_wrap ? 6'h00 : step_reg + 6'h01;
                end
            end
        end
    end

    // ========================================================================
    // Shared reduced-rate wave for blanking; it restarts on raw blanking entry, retimed channels pick it up at the next pixel tick
    assign any_blank = horizontal_blanking || (|blank_rt_reg);
    assign slow_mode = (retime_reg.div != 3'h0);

    blank_divider u_blank_divider (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .ce         (ce),
        .run        (run),
        .blank      (any_blank),
        .pixel_tick (pixel_tick),
        .div        (retime_reg.div),
        .slow_wave  (slow_wave)
    );

    // ========================================================================
    // Per-channel edge wave, blanking retime and polarity
    for (genvar ch = 0; ch < hclk_pkg::NUM_CH; ch++) begin : g_ch
        edge_wave u_edge_wave (
            .sys_clk (sys_clk),
            .rst_b   (rst_b),
            .ce      (ce),
            .run     (run),
            .step_en (step_en),
            .step    (step_reg),
            .cfg     (edge_cfg_reg[ch]),
            .wave    (wave[ch])
        );

        // Resync to the pixel tick shared by all channels costs up to one pixel of delay
        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                blank_rt_reg[ch] <= 1'b0;
            end else if (ce) begin
                if (!run) begin
                    blank_rt_reg[ch] <= 1'b0;
                end else if (pixel_tick) begin
                    blank_rt_reg[ch] <= horizontal_blanking;
                end
            end
        end

        if (ch == hclk_pkg::CH_RGATE) begin : g_rg
            // Reset gate keeps clocking through blanking
            assign blank_eff[ch] = 1'b0;
        end else if (ch == hclk_pkg::CH_LAST) begin : g_last
            assign blank_eff[ch] = retime_reg.last_stage_blank_enable &&
                (retime_reg.resync[ch] ? blank_rt_reg[ch] : horizontal_blanking);
        end else begin : g_pair
            assign blank_eff[ch] = retime_reg.resync[ch] ? blank_rt_reg[ch]
                                                         : horizontal_blanking;
        end

        // Divide 0 keeps pixel rate, otherwise one over twice div
        assign shaped[ch]  = (blank_eff[ch] && slow_mode) ? slow_wave : wave[ch];
        assign pol_out[ch] = edge_cfg_reg[ch].pol ? shaped[ch] : ~shaped[ch];
    end

    // ========================================================================
    // Output flops; second phase of each pair is the complement of the first
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            horizontal_clock_one        <= 1'b0;
            horizontal_clock_two        <= 1'b1;
            horizontal_clock_three      <= 1'b0;
            horizontal_clock_four       <= 1'b1;
            last_stage_horizontal_clock <= 1'b0;
            reset_gate_clock            <= 1'b0;
            drive_levels                <= hclk_pkg::DRIVE_RST;
            core_running                <= 1'b0;
        end else if (ce) begin
            horizontal_clock_one        <= pol_out[hclk_pkg::CH_PAIR_A];
            horizontal_clock_two        <= ~pol_out[hclk_pkg::CH_PAIR_A];
            horizontal_clock_three      <= pol_out[hclk_pkg::CH_PAIR_B];
            horizontal_clock_four       <= ~pol_out[hclk_pkg::CH_PAIR_B];
            last_stage_horizontal_clock <= pol_out[hclk_pkg::CH_LAST];
            reset_gate_clock            <= pol_out[hclk_pkg::CH_RGATE];
            drive_levels                <= drive_reg;
            core_running                <= run;
        end
    end

endmodule : hclk_timing
`default_nettype wire

// ---- tb/ccd_sensor_model.sv ----
// Sensor-side monitor that times the horizontal and reset gate clock inputs
`timescale 1ns/1ps
`default_nettype none

module ccd_sensor_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  clk_in,
    output logic      [7:0]  high_len [4],
    output logic      [15:0] rises [4]
);
    logic [3:0] prev;
    logic [7:0] run_len [4];

    // ========================================================================
    // The sensor only listens: it keeps the last full high time and edge count
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                run_len[i]  <= 8'h00;
                high_len[i] <= 8'h00;
                rises[i]    <= 16'h0000;
            end
        end else begin
            prev <= clk_in;
            for (int i = 0; i < 4; i++) begin
                run_len[i] <= clk_in[i] ? run_len[i] + 8'h01 : 8'h00;
                if (prev[i] && !clk_in[i]) high_len[i] <= run_len[i];
                if (!prev[i] && clk_in[i]) rises[i] <= rises[i] + 16'h0001;
            end
        end
    end
endmodule : ccd_sensor_model

`default_nettype wire

// ---- tb/hclk_timing_checker.sv ----
// Port-level assertions for the horizontal clock generator
`timescale 1ns/1ps
`default_nettype none

module hclk_timing_checker #(
    parameter int PIXEL_STEPS = 64
) (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        ce,
    input wire logic        serial_clock,
    input wire logic        serial_load_n,
    input wire logic        serial_data,
    input wire logic        horizontal_blanking,
    input wire logic        horizontal_clock_one,
    input wire logic        horizontal_clock_two,
    input wire logic        horizontal_clock_three,
    input wire logic        horizontal_clock_four,
    input wire logic        last_stage_horizontal_clock,
    input wire logic        reset_gate_clock,
    input wire logic [23:0] drive_levels,
    input wire logic        core_running
);
    // ========================================================================
    // Assertions, all in the system clock domain
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_pair_a_complement: assert property (horizontal_clock_two == !horizontal_clock_one)
        else $error("pair A outputs not complementary");
    a_pair_b_complement: assert property (horizontal_clock_four == !horizontal_clock_three)
        else $error("pair B outputs not complementary");
    // Wave and output flops need a few cycles to drain after the core halts
    a_halted_core_still: assert property (!core_running [*5] |->
        $stable(reset_gate_clock) && $stable(horizontal_clock_one))
        else $error("clock moved while core held");
    a_reset_values_seen: assert property ($rose(rst_b) |->
        drive_levels == hclk_pkg::DRIVE_RST && !core_running && !reset_gate_clock)
        else $error("wrong value out of reset");
    // Register lands on the last bit's edge and the output flop one edge later
    a_run_bit_write: assert property ($changed(core_running) |->
        !$past(serial_load_n, 2) && $past(serial_clock, 2))
        else $error("core run bit changed outside a frame");
    a_drive_bit_write: assert property ($changed(drive_levels) |->
        !$past(serial_load_n, 2) && $past(serial_clock, 2))
        else $error("drive levels changed outside a frame");
    a_idle_frame_quiet: assert property (serial_load_n [*2] |->
        $stable(drive_levels) && $stable(core_running))
        else $error("register changed with no frame open");
    a_enable_freezes: assert property (!ce |=> $stable(drive_levels)
        && $stable(core_running) && $stable(horizontal_clock_three))
        else $error("state moved while clock enable low");
endmodule : hclk_timing_checker

`default_nettype wire

// ---- tb/hclk_timing_test.sv ----
// Self-checking testbench of the horizontal clock generator
`timescale 1ns/1ps
`default_nettype none

module hclk_timing_test;
    localparam int P = 32; // Short pixel period keeps the run brief
    logic        sys_clk, rst_b, ce, sck, load_n, sdata, blank;
    logic        clk_one, clk_two, clk_three, clk_four, clk_last, clk_gate, running;
    logic [23:0] drive;
    logic [7:0]  high_len [4];
    logic [15:0] rises [4];
    int          fail_count, tests_run;

    hclk_timing #(.PIXEL_STEPS(P)) hclk_timing_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .ce(ce), .serial_clock(sck), .serial_load_n(load_n), .serial_data(sdata),
        .horizontal_blanking(blank), .horizontal_clock_one(clk_one),
        .horizontal_clock_two(clk_two), .horizontal_clock_three(clk_three),
        .horizontal_clock_four(clk_four), .last_stage_horizontal_clock(clk_last),
        .reset_gate_clock(clk_gate), .drive_levels(drive), .core_running(running));
    ccd_sensor_model ccd_sensor_model_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_in({clk_gate, clk_last, clk_three, clk_one}), .high_len(high_len),
        .rises(rises));

    // ========================================================================
    // Shared tasks
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // Frame is address then data, LSB first; fewer than 32 bits aborts it
    task automatic ser_write(input logic [7:0] addr, input logic [23:0] data, input int nbits);
        logic [31:0] frame;
        frame = {data, addr};
        @(negedge sys_clk) load_n = 1'b0;
        @(negedge sys_clk);
        for (int i = 0; i < nbits; i++) begin
            sdata = frame[i];
            @(negedge sys_clk) sck = 1'b1;
            @(negedge sys_clk) sck = 1'b0;
        end
        @(negedge sys_clk) load_n = 1'b1;
        @(negedge sys_clk);
    endtask : ser_write

    task automatic set_edges(input int ch, input logic pol, input logic [5:0] r, input logic [5:0] f);
        ser_write(hclk_pkg::ADDR_PAIR_A + 8'(ch), {7'h00, pol, 2'b00, f, 2'b00, r}, 32);
    endtask : set_edges

    task automatic pause(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : pause

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // ========================================================================
    // Scenarios
    task automatic t_defaults();
        logic [7:0] exp [4] = '{8'h14, 8'h14, 8'h14, 8'h0A};
        check("core idle", 24'(running), 24'h0);
        ser_write(hclk_pkg::ADDR_CORE_RUN, 24'h000001, 32);
        check("core run", 24'(running), 24'h1);
        pause(3 * P);
        for (int c = 0; c < 4; c++) check("default high", 24'(high_len[c]), 24'(exp[c]));
    endtask : t_defaults

    task automatic t_positions();
        for (int c = 0; c < 4; c++) set_edges(c, 1'b1, 6'(c + 1), 6'(9 + 5 * c));
        pause(3 * P);
        for (int c = 0; c < 4; c++) check("edge high", 24'(high_len[c]), 24'(8 + 4 * c));
        set_edges(0, 1'b0, 6'h01, 6'h09);
        pause(3 * P);
        check("inverted high", 24'(high_len[0]), 24'(P - 8));
        set_edges(0, 1'b1, 6'h01, 6'h09);
        ser_write(hclk_pkg::ADDR_CLK_HALVE, 24'h000001, 32);
        pause(5 * P);
        check("halved high", 24'(high_len[0]), 24'h10);
        ser_write(hclk_pkg::ADDR_CLK_HALVE, 24'h000000, 32);
        pause(3 * P);
    endtask : t_positions

    task automatic t_blanking();
        // Entries are {divide, last-stage enable, resync bits}; 7'h3F sets every resync
        logic [6:0] tbl [4] = '{7'h10, 7'h3F, 7'h78, 7'h08};
        int div;
        for (int e = 0; e < 4; e++) begin
            div = int'(tbl[e][6:4]);
            ser_write(hclk_pkg::ADDR_RETIME, {17'h0, tbl[e]}, 32);
            @(negedge sys_clk) blank = 1'b1;
            pause(3 * div * P + 2 * P);
            check("blank pair", 24'(high_len[0]), 24'(div != 0 ? div * P : 8));
            check("blank pair b", 24'(high_len[1]), 24'(div != 0 ? div * P : 12));
            check("blank last", 24'(high_len[2]), 24'((div != 0 && tbl[e][3]) ? div * P : 16));
            check("blank gate", 24'(high_len[3]), 24'h14);
            @(negedge sys_clk) blank = 1'b0;
            pause(3 * P);
        end
    endtask : t_blanking

    task automatic t_stop_and_frames();
        logic [15:0] count;
        @(negedge sys_clk) ce = 1'b0;
        pause(6);
        ce = 1'b1;
        ser_write(hclk_pkg::ADDR_CORE_RUN, 24'h000000, 32);
        pause(2 * P);
        count = rises[3];
        pause(2 * P);
        check("halted edges", 24'(rises[3]), 24'(count));
        ser_write(hclk_pkg::ADDR_CORE_RUN, 24'h000001, 16);
        check("aborted frame", 24'(running), 24'h0);
        ser_write(8'h3F, 24'h000001, 32);
        check("unmapped write", 24'(running), 24'h0);
        ser_write(hclk_pkg::ADDR_CORE_RUN, 24'h000001, 32);
        check("resumed", 24'(running), 24'h1);
        ser_write(hclk_pkg::ADDR_DRIVE, 24'h5A3C96, 32);
        check("drive write", drive, 24'h5A3C96);
    endtask : t_stop_and_frames

    // ========================================================================
    // Clock, watchdog and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end

    initial begin
        fail_count = 0;
        tests_run = 0;
        rst_b = 1'b0;
        ce = 1'b1;
        sck = 1'b0;
        load_n = 1'b1;
        sdata = 1'b0;
        blank = 1'b0;
        pause(8);
        rst_b = 1'b1;
        t_defaults();
        t_positions();
        t_blanking();
        t_stop_and_frames();
        final_report();
    end
endmodule : hclk_timing_test

bind hclk_timing hclk_timing_checker #(.PIXEL_STEPS(PIXEL_STEPS)) hclk_timing_checker_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .serial_clock(serial_clock),
    .serial_load_n(serial_load_n), .serial_data(serial_data),
    .horizontal_blanking(horizontal_blanking), .horizontal_clock_one(horizontal_clock_one),
    .horizontal_clock_two(horizontal_clock_two), .horizontal_clock_three(horizontal_clock_three),
    .horizontal_clock_four(horizontal_clock_four),
    .last_stage_horizontal_clock(last_stage_horizontal_clock),
    .reset_gate_clock(reset_gate_clock), .drive_levels(drive_levels),
    .core_running(core_running));

`default_nettype wire
